// *** timer_pkg.sv ***
package timer_pkg;

  localparam int PRE_W = 10;
  localparam int TAP8_W = 3;
  localparam int TAP64_W = 6;
  localparam int TAP256_W = 8;
  localparam int TAP1024_W = 10;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_CK = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam int IDX_W = 8;
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] IDX_CAPTURE = 8'h24;
  localparam logic [7:0] IDX_CMP_B = 8'h28;
  localparam logic [7:0] IDX_CMP_A = 8'h2A;
  localparam logic [7:0] IDX_C1_VALUE = 8'h2C;
  localparam logic [7:0] IDX_C1_CTRL_B = 8'h2E;
  localparam logic [7:0] IDX_C1_CTRL_A = 8'h2F;
  localparam logic [7:0] IDX_C0_VALUE = 8'h32;
  localparam logic [7:0] IDX_C0_CTRL = 8'h33;
  localparam logic [7:0] IDX_FLAGS = 8'h38;
  localparam logic [7:0] IDX_MASK = 8'h39;

  localparam logic [7:0] C0_CTRL_WMASK = 8'h07;
  localparam logic [7:0] C1A_WMASK = 8'hF3;
  localparam logic [7:0] C1B_WMASK = 8'hCF;
  localparam logic [7:0] FLAG_WMASK = 8'hEA;
  localparam int CMP_SEL_BIT = 8;

  localparam int FLG_C1_OVF = 7;
  localparam int FLG_CMP_A = 6;
  localparam int FLG_CMP_B = 5;
  localparam int FLG_CAPT = 3;
  localparam int FLG_C0_OVF = 1;

  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8 = 2'h1;
  localparam logic [1:0] PWM_9 = 2'h2;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam int PWM_CMP_W = 10;

  localparam logic [7:0] C0_MAX = 8'hFF;
  localparam logic [15:0] C1_MAX = 16'hFFFF;
  localparam int NOISE_SAMPLES = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [IDX_W-1:0] idx;
  } bus_phase_s;

  typedef struct packed {
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic [1:0] pwm;
    logic noise_en;
    logic edge_rise;
    logic clr_on_match;
    logic [2:0] clksel;
  } c1_cfg_s;

endpackage

// *** clk_source_sel.sv ***
`timescale 1ns/1ps
module clk_source_sel
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] clksel,
  input wire logic [PRE_W-1:0] pre_cnt,
  input wire logic ext_pin,
  output logic tick
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Pin is asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= ext_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_comb begin
    case (clksel)
      CS_STOP: tick = 1'b0;
      CS_CK: tick = 1'b1;
      CS_DIV8: tick = &pre_cnt[TAP8_W-1:0];
      CS_DIV64: tick = &pre_cnt[TAP64_W-1:0];
      CS_DIV256: tick = &pre_cnt[TAP256_W-1:0];
      CS_DIV1024: tick = &pre_cnt[TAP1024_W-1:0];
      CS_EXT_FALL: tick = prev_r & ~sync2_r;
      CS_EXT_RISE: tick = ~prev_r & sync2_r;
      default: tick = 1'b0;
    endcase
  end

endmodule

// *** dual_timer_counter_prescaler.sv ***
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
// Summary of operation
// - One shared 10-bit prescaler feeds both counters
// - Counter0 clock select: stop, CK, taps, pin
// - Counter1 clock select uses same encoding
// - External count pins synchronised, sampled rising hclk
// - Counter0 counts up, writable, resumes next cycle
// - Unused control bits read zero
// - Counter0 overflow sets its flag; request gated by its mask
// - Counter1 compares A and B, raises flags
// - Clear-on-match A zeroes counter1, B never
// - Clear follows match; ignored in PWM
// - Compare output modes: off, toggle, low, high
// - PWM select: off, 8, 9, 10 bit
// - PWM counts up to top, back down
// - Capture copies counter1 into capture register
// - Comparator output may trigger capture instead
// - Edge select: zero falling, one rising
// - Filter off: first sampled edge captures
// - Filter on: four equal samples needed
module dual_timer_counter_prescaler
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic count0_ext_pin,
  input wire logic count1_ext_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  output logic compare_out_pin_a,
  output logic compare_out_pin_a_oe,
  output logic compare_out_pin_b,
  output logic compare_out_pin_b_oe,
  output logic [7:0] event_req
);

  logic [PRE_W-1:0] pre_r;
  bus_phase_s ph_r;
  logic [7:0] c0_ctrl_r;
  logic [7:0] c0_value_r;
  logic [7:0] c1a_r;
  logic [7:0] c1b_r;
  logic [15:0] c1_value_r;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [15:0] capture_r;
  logic [7:0] flags_r;
  logic [7:0] mask_r;
  dir_e dir_r;
  logic c1_upd_r;
  logic pin_a_r;
  logic pin_b_r;
  logic oe_a_r;
  logic oe_b_r;
  logic cap_pin1_r;
  logic cap_pin2_r;
  logic cmp_in1_r;
  logic cmp_in2_r;
  logic [NOISE_SAMPLES-1:0] hist_r;
  logic filt_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [7:0] event_req_r;

  c1_cfg_s cfg;
  logic tick0;
  logic tick1;
  logic wr_en;
  logic [7:0] wbyte;
  logic pwm_on;
  logic [15:0] top;
  logic [15:0] cmp_a_eff;
  logic [15:0] cmp_b_eff;
  logic match_a;
  logic match_b;
  logic ctc_hit;
  logic c0_ovf;
  logic c1_ovf;
  logic cap_event;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  assign cfg = c1_cfg_s'{mode_a: c1a_r[7:6], mode_b: c1a_r[5:4], pwm: c1a_r[1:0],
                         noise_en: c1b_r[7], edge_rise: c1b_r[6],
                         clr_on_match: c1b_r[3], clksel: c1b_r[2:0]};
  assign wr_en = ph_r.valid & ph_r.write;
  assign wbyte = hwdata[7:0];

  // Shared prescaler runs free from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  clk_source_sel u_src0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .clksel(c0_ctrl_r[2:0]),
    .pre_cnt(pre_r),
    .ext_pin(count0_ext_pin),
    .tick(tick0)
  );

  clk_source_sel u_src1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .clksel(cfg.clksel),
    .pre_cnt(pre_r),
    .ext_pin(count1_ext_pin),
    .tick(tick1)
  );

  // Zero-wait slave: address phase latched, write applied in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= '0;
    end else begin
      ph_r.valid <= hsel & hready & htrans[HTRANS_ACTIVE_BIT];
      ph_r.write <= hwrite;
      ph_r.idx <= haddr[ADDR_LSB +: IDX_W];
    end
  end

  function automatic logic [31:0] read_mux(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_C0_CTRL: read_mux = {24'h000000, c0_ctrl_r & C0_CTRL_WMASK};
      IDX_C0_VALUE: read_mux = {24'h000000, c0_value_r};
      IDX_C1_CTRL_A: read_mux = {24'h000000, c1a_r & C1A_WMASK};
      IDX_C1_CTRL_B: read_mux = {24'h000000, c1b_r & C1B_WMASK};
      IDX_C1_VALUE: read_mux = {16'h0000, c1_value_r};
      IDX_CMP_A: read_mux = {16'h0000, cmp_a_r};
      IDX_CMP_B: read_mux = {16'h0000, cmp_b_r};
      IDX_CAPTURE: read_mux = {16'h0000, capture_r};
      IDX_FLAGS: read_mux = {24'h000000, flags_r};
      IDX_MASK: read_mux = {24'h000000, mask_r};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  // Read data sampled at the address phase, so it shows pre-write state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
      if (hsel && hready && htrans[HTRANS_ACTIVE_BIT] && !hwrite) begin
        hrdata_r <= read_mux(haddr[ADDR_LSB +: IDX_W]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c0_ctrl_r <= RST_BYTE;
      c1a_r <= RST_BYTE;
      c1b_r <= RST_BYTE;
      cmp_a_r <= RST_WORD;
      cmp_b_r <= RST_WORD;
      mask_r <= RST_BYTE;
    end else if (wr_en) begin
      case (ph_r.idx)
        IDX_C0_CTRL: c0_ctrl_r <= wbyte & C0_CTRL_WMASK;
        IDX_C1_CTRL_A: c1a_r <= wbyte & C1A_WMASK;
        IDX_C1_CTRL_B: c1b_r <= wbyte & C1B_WMASK;
        IDX_CMP_A: cmp_a_r <= hwdata[15:0];
        IDX_CMP_B: cmp_b_r <= hwdata[15:0];
        IDX_MASK: mask_r <= wbyte & FLAG_WMASK;
        default: ;
      endcase
    end
  end

  // Counter0: a write wins over a tick and counting resumes next cycle
  assign c0_ovf = tick0 && !(wr_en && ph_r.idx == IDX_C0_VALUE) && c0_value_r == C0_MAX;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c0_value_r <= RST_BYTE;
    end else if (wr_en && ph_r.idx == IDX_C0_VALUE) begin
      c0_value_r <= wbyte;
    end else if (tick0) begin
      c0_value_r <= c0_value_r + 1'b1;
    end
  end

  // Counter1
  assign pwm_on = cfg.pwm != PWM_OFF;
  always_comb begin
    case (cfg.pwm)
      PWM_8: top = TOP_8;
      PWM_9: top = TOP_9;
      default: top = TOP_10;
    endcase
  end

  // PWM compares only the low ten bits of each compare value
  assign cmp_a_eff = pwm_on ? {6'h00, cmp_a_r[PWM_CMP_W-1:0]} : cmp_a_r;
  assign cmp_b_eff = pwm_on ? {6'h00, cmp_b_r[PWM_CMP_W-1:0]} : cmp_b_r;
  assign match_a = c1_upd_r && c1_value_r == cmp_a_eff;
  assign match_b = c1_upd_r && c1_value_r == cmp_b_eff;
  assign ctc_hit = cfg.clr_on_match && !pwm_on && c1_value_r == cmp_a_r;
  assign c1_ovf = tick1 && !(wr_en && ph_r.idx == IDX_C1_VALUE) &&
                  (pwm_on ? (dir_r == DIR_DOWN && c1_value_r == RST_WORD)
                          : (c1_value_r == C1_MAX && !ctc_hit));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1_value_r <= RST_WORD;
      dir_r <= DIR_UP;
      c1_upd_r <= 1'b0;
    end else begin
      c1_upd_r <= 1'b0;
      if (wr_en && ph_r.idx == IDX_C1_VALUE) begin
        c1_value_r <= hwdata[15:0];
        dir_r <= DIR_UP;
      end else if (tick1) begin
        c1_upd_r <= 1'b1;
        if (pwm_on) begin
          case (dir_r)
            DIR_UP: begin
              if (c1_value_r >= top) begin
                c1_value_r <= c1_value_r - 1'b1;
                dir_r <= DIR_DOWN;
              end else begin
                c1_value_r <= c1_value_r + 1'b1;
              end
            end
            DIR_DOWN: begin
              if (c1_value_r == RST_WORD) begin
                c1_value_r <= c1_value_r + 1'b1;
                dir_r <= DIR_UP;
              end else begin
                c1_value_r <= c1_value_r - 1'b1;
              end
            end
            default: dir_r <= DIR_UP;
          endcase
        end else if (ctc_hit) begin
          // Counter rests one timer period on the match value, then clears
          c1_value_r <= RST_WORD;
        end else begin
          c1_value_r <= c1_value_r + 1'b1;
          dir_r <= DIR_UP;
        end
      end
    end
  end

  function automatic logic pin_next(input logic [1:0] mode, input logic pwm,
                                    input dir_e dir, input logic cur);
    logic up;
    up = dir == DIR_UP;
    case (mode)
      OM_TOGGLE: pin_next = pwm ? cur : ~cur;
      OM_CLEAR: pin_next = pwm ? ~up : 1'b0;
      OM_SET: pin_next = pwm ? up : 1'b1;
      default: pin_next = cur;
    endcase
  endfunction

  // Pin drivers; enable only while a mode is connected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_r <= 1'b0;
      pin_b_r <= 1'b0;
      oe_a_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else begin
      oe_a_r <= cfg.mode_a != OM_OFF;
      oe_b_r <= cfg.mode_b != OM_OFF;
      if (match_a) begin
        pin_a_r <= pin_next(cfg.mode_a, pwm_on, dir_r, pin_a_r);
      end
      if (match_b) begin
        pin_b_r <= pin_next(cfg.mode_b, pwm_on, dir_r, pin_b_r);
      end
    end
  end

  // Capture inputs, each synchronised before the source mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_pin1_r <= 1'b0;
      cap_pin2_r <= 1'b0;
      cmp_in1_r <= 1'b0;
      cmp_in2_r <= 1'b0;
    end else begin
      cap_pin1_r <= capture_input_pin;
      cap_pin2_r <= cap_pin1_r;
      cmp_in1_r <= comparator_output;
      cmp_in2_r <= cmp_in1_r;
    end
  end

  logic cmp_sel_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_sel_r <= 1'b0;
    end else if (wr_en && ph_r.idx == IDX_C1_CTRL_B) begin
      cmp_sel_r <= hwdata[CMP_SEL_BIT];
    end
  end

  logic src_now;
  assign src_now = cmp_sel_r ? cmp_in2_r : cap_pin2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= '0;
      filt_r <= 1'b0;
    end else begin
      hist_r <= {hist_r[NOISE_SAMPLES-2:0], src_now};
      if (&hist_r || ~|hist_r) begin
        filt_r <= hist_r[0];
      end
    end
  end

  always_comb begin
    if (cfg.noise_en) begin
      // Level must hold for all samples before it counts as an edge
      cap_event = (&hist_r || ~|hist_r) && hist_r[0] != filt_r &&
                  hist_r[0] == cfg.edge_rise;
    end else begin
      cap_event = src_now != hist_r[0] && src_now == cfg.edge_rise;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_r <= RST_WORD;
    end else if (cap_event) begin
      capture_r <= c1_value_r;
    end
  end

  // Flags clear by writing one; a simultaneous event keeps the flag set
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLG_C1_OVF] = c1_ovf;
    flag_set[FLG_CMP_A] = match_a;
    flag_set[FLG_CMP_B] = match_b;
    flag_set[FLG_CAPT] = cap_event;
    flag_set[FLG_C0_OVF] = c0_ovf;
  end
  assign flag_clr = (wr_en && ph_r.idx == IDX_FLAGS) ? (wbyte & FLAG_WMASK) : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= RST_BYTE;
      event_req_r <= RST_BYTE;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
      event_req_r <= flags_r & mask_r;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign compare_out_pin_a = pin_a_r;
  assign compare_out_pin_a_oe = oe_a_r;
  assign compare_out_pin_b = pin_b_r;
  assign compare_out_pin_b_oe = oe_b_r;
  assign event_req = event_req_r;

endmodule

// *** ext_pins_model.sv ***
`timescale 1ns/1ps
module ext_pins_model (
  input wire logic hclk,
  output logic count0_ext_pin,
  output logic count1_ext_pin,
  output logic capture_input_pin,
  output logic comparator_output
);
  initial begin
    count0_ext_pin = 1'h0;
    count1_ext_pin = 1'h0;
    capture_input_pin = 1'h0;
    comparator_output = 1'h0;
  end

  // Pins change only just after a clock edge
  task automatic drive(input int unsigned which, input logic v);
    @(posedge hclk);
    case (which)
      0: count0_ext_pin <= v;
      1: count1_ext_pin <= v;
      2: capture_input_pin <= v;
      default: comparator_output <= v;
    endcase
  endtask

  // Each level held three clocks, wider than the minimum spacing
  task automatic pulse(input int unsigned which, input int unsigned n);
    repeat (n) begin
      drive(which, 1'h1);
      repeat (2) @(posedge hclk);
      drive(which, 1'h0);
      repeat (2) @(posedge hclk);
    end
  endtask
endmodule

// *** dual_timer_monitor.sv ***
`timescale 1ns/1ps
module dual_timer_monitor
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic compare_out_pin_a,
  input wire logic compare_out_pin_a_oe,
  input wire logic compare_out_pin_b,
  input wire logic compare_out_pin_b_oe,
  input wire logic [7:0] event_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_take;
  logic [7:0] rd_idx;
  assign rd_take = hsel && hready && htrans[HTRANS_ACTIVE_BIT] && !hwrite;
  assign rd_idx = haddr[9:2];

  property p_c0_ctrl_rsvd;
    rd_take && rd_idx == IDX_C0_CTRL |=> hrdata[31:3] == 29'h0;
  endproperty
  a_c0_ctrl_rsvd: assert property (p_c0_ctrl_rsvd)
    else $error("counter0 control reads nonzero reserved bits");

  property p_c1a_rsvd;
    rd_take && rd_idx == IDX_C1_CTRL_A |=> hrdata[31:8] == 24'h0 && hrdata[3:2] == 2'h0;
  endproperty
  a_c1a_rsvd: assert property (p_c1a_rsvd)
    else $error("counter1 control a reads nonzero reserved bits");

  property p_c1b_rsvd;
    rd_take && rd_idx == IDX_C1_CTRL_B |=> hrdata[31:8] == 24'h0 && hrdata[5:4] == 2'h0;
  endproperty
  a_c1b_rsvd: assert property (p_c1b_rsvd)
    else $error("counter1 control b reads nonzero reserved bits");

  property p_c0_width;
    rd_take && rd_idx == IDX_C0_VALUE |=> hrdata[31:8] == 24'h0;
  endproperty
  a_c0_width: assert property (p_c0_width)
    else $error("counter0 value wider than eight bits");

  property p_capt_width;
    rd_take && rd_idx == IDX_CAPTURE |=> hrdata[31:16] == 16'h0;
  endproperty
  a_capt_width: assert property (p_capt_width)
    else $error("capture value wider than sixteen bits");

  property p_pin_a_gated;
    $changed(compare_out_pin_a) |-> compare_out_pin_a_oe || $past(compare_out_pin_a_oe);
  endproperty
  a_pin_a_gated: assert property (p_pin_a_gated)
    else $error("compare pin a moved while disconnected");

  property p_pin_b_gated;
    (!compare_out_pin_b_oe)[*2] |-> $stable(compare_out_pin_b);
  endproperty
  a_pin_b_gated: assert property (p_pin_b_gated)
    else $error("compare pin b moved while disconnected");

  property p_evt_unused;
    event_req[4] == 1'h0 && event_req[2] == 1'h0 && event_req[0] == 1'h0;
  endproperty
  a_evt_unused: assert property (p_evt_unused)
    else $error("request raised on an unused flag position");

  c_pin_a_move: cover property ($changed(compare_out_pin_a));
  c_c0_ovf_req: cover property (event_req[FLG_C0_OVF]);
  c_capt_read: cover property (rd_take && rd_idx == IDX_CAPTURE);
endmodule

bind dual_timer_counter_prescaler dual_timer_monitor dual_timer_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .compare_out_pin_a(compare_out_pin_a), .compare_out_pin_a_oe(compare_out_pin_a_oe),
  .compare_out_pin_b(compare_out_pin_b), .compare_out_pin_b_oe(compare_out_pin_b_oe),
  .event_req(event_req)
);

// *** tb_dual_timer_counter_prescaler.sv ***
`timescale 1ns/1ps
module tb_dual_timer_counter_prescaler
  import timer_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, mx;
  logic [1:0] htrans, seen;
  logic [7:0] event_req;
  logic pa, pa_oe, pb, pb_oe, c0_pin, c1_pin, cap_pin, cmp_out;
  int failures, checks_done, cyc, div;
  int divs[5] = '{1, 8, 64, 256, 1024};
  logic [1:0] modes[4] = '{OM_SET, OM_CLEAR, OM_TOGGLE, OM_OFF};

  dual_timer_counter_prescaler dual_timer_counter_prescaler_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .count0_ext_pin(c0_pin), .count1_ext_pin(c1_pin), .capture_input_pin(cap_pin),
    .comparator_output(cmp_out), .compare_out_pin_a(pa), .compare_out_pin_a_oe(pa_oe),
    .compare_out_pin_b(pb), .compare_out_pin_b_oe(pb_oe), .event_req(event_req)
  );
  ext_pins_model ext_pins_model_inst (
    .hclk(hclk), .count0_ext_pin(c0_pin), .count1_ext_pin(c1_pin),
    .capture_input_pin(cap_pin), .comparator_output(cmp_out)
  );

  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if (!((got >= lo) === 1'h1 && (got <= hi) === 1'h1)) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Address phase held until hready, then data phase until hready again
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'h1, idx, d, dummy);
  endtask

  task automatic rd(input logic [7:0] idx);
    bus(1'h0, idx, 32'h0, r);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(r, exp);
  endtask

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    foreach (modes[i]) rdc(8'h2E + 8'(i), 32'h0);
    rdc(8'h00, 32'h0);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    wr(IDX_C0_CTRL, 32'hFF);
    rdc(IDX_C0_CTRL, 32'h07);
    wr(IDX_C1_CTRL_A, 32'hFF);
    rdc(IDX_C1_CTRL_A, 32'hF3);
    wr(IDX_C1_CTRL_B, 32'hFF);
    rdc(IDX_C1_CTRL_B, 32'hCF);
    wr(IDX_C1_CTRL_A, 32'h0);
    wr(IDX_C1_CTRL_B, 32'h0);
    wr(IDX_FLAGS, 32'hFF);
    $display("test registers done");

    wr(IDX_C0_CTRL, 32'h0);
    wr(IDX_C0_VALUE, 32'h5A);
    rdc(IDX_C0_VALUE, 32'h5A);
    wr(IDX_C0_CTRL, {29'h0, CS_EXT_RISE});
    ext_pins_model_inst.pulse(0, 3);
    repeat (8) @(posedge hclk);
    rdc(IDX_C0_VALUE, 32'h5D);
    wr(IDX_C0_CTRL, {29'h0, CS_EXT_FALL});
    ext_pins_model_inst.pulse(0, 2);
    repeat (8) @(posedge hclk);
    rdc(IDX_C0_VALUE, 32'h5F);
    wr(IDX_MASK, 32'h02);
    wr(IDX_C0_VALUE, 32'hFF);
    ext_pins_model_inst.pulse(0, 1);
    repeat (8) @(posedge hclk);
    rdc(IDX_C0_VALUE, 32'h00);
    rdc(IDX_FLAGS, 32'h02);
    chk({24'h0, event_req}, 32'h02);
    wr(IDX_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk({24'h0, event_req}, 32'h0);
    wr(IDX_FLAGS, 32'h02);
    rdc(IDX_FLAGS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      div = divs[i];
      wr(IDX_C0_CTRL, 32'h0);
      wr(IDX_C0_VALUE, 32'h0);
      wr(IDX_C0_CTRL, 32'(CS_CK) + 32'(i));
      repeat ((div == 1) ? 100 : 1024) @(posedge hclk);
      wr(IDX_C0_CTRL, 32'h0);
      rd(IDX_C0_VALUE);
      mx = (div == 1) ? 100 : 1024 / div;
      chk_rng(r, mx, mx + ((div == 1) ? 4 : 1));
    end
    $display("test counter0 done");

    wr(IDX_C1_VALUE, 32'h0);
    wr(IDX_C1_CTRL_B, {29'h0, CS_EXT_RISE});
    ext_pins_model_inst.pulse(1, 2);
    repeat (8) @(posedge hclk);
    rdc(IDX_C1_VALUE, 32'h2);
    wr(IDX_C1_CTRL_B, {29'h0, CS_EXT_FALL});
    ext_pins_model_inst.pulse(1, 1);
    repeat (8) @(posedge hclk);
    rdc(IDX_C1_VALUE, 32'h3);
    wr(IDX_C1_CTRL_B, 32'h0);
    wr(IDX_FLAGS, 32'hFF);
    wr(IDX_CMP_A, 32'd20);
    wr(IDX_CMP_B, 32'd5);
    wr(IDX_C1_VALUE, 32'h0);
    wr(IDX_C1_CTRL_B, 32'h09);
    mx = 0;
    repeat (30) begin
      rd(IDX_C1_VALUE);
      if (r > mx) mx = r;
    end
    chk_rng(mx, 32'd18, 32'd20);
    rd(IDX_FLAGS);
    chk(r & 32'hE0, 32'h60);
    wr(IDX_MASK, 32'h0);
    foreach (modes[i]) begin
      wr(IDX_C1_CTRL_A, {24'h0, modes[i], modes[i], 4'h0});
      seen = 2'h0;
      repeat (50) begin
        @(posedge hclk);
        seen = seen | {pb, pa};
      end
      chk({pb_oe, pa_oe}, {2{modes[i] != OM_OFF}});
      if (modes[i] == OM_TOGGLE) chk(seen, 2'h3);
      else if (modes[i] != OM_OFF) chk({pb, pa}, {2{modes[i] == OM_SET}});
    end
    for (int p = 1; p < 4; p++) begin
      wr(IDX_C1_CTRL_B, 32'h0);
      wr(IDX_C1_VALUE, 32'h0);
      wr(IDX_C1_CTRL_A, 32'h80 + 32'(p));
      wr(IDX_C1_CTRL_B, 32'h09);
      mx = 0;
      seen = 2'h0;
      repeat (800) begin
        rd(IDX_C1_VALUE);
        if (r > mx) mx = r;
        seen = seen | {~pa, pa};
      end
      chk_rng(mx, (32'h100 << (p - 1)) - 4, (32'h100 << (p - 1)) - 1);
      chk(seen, 2'h3);
    end
    rd(IDX_FLAGS);
    chk(r & 32'h80, 32'h80);
    wr(IDX_C1_CTRL_A, 32'h0);
    wr(IDX_C1_CTRL_B, 32'h0);
    $display("test counter1 done");

    wr(IDX_FLAGS, 32'hFF);
    wr(IDX_C1_VALUE, 32'h1234);
    wr(IDX_C1_CTRL_B, 32'h40);
    ext_pins_model_inst.drive(2, 1'h1);
    repeat (10) @(posedge hclk);
    rdc(IDX_CAPTURE, 32'h1234);
    rd(IDX_FLAGS);
    chk(r & 32'h08, 32'h08);
    wr(IDX_C1_CTRL_B, 32'h00);
    wr(IDX_C1_VALUE, 32'h0BCD);
    ext_pins_model_inst.drive(2, 1'h0);
    repeat (10) @(posedge hclk);
    rdc(IDX_CAPTURE, 32'h0BCD);
    wr(IDX_C1_CTRL_B, 32'hC0);
    wr(IDX_C1_VALUE, 32'h0111);
    ext_pins_model_inst.drive(2, 1'h1);
    ext_pins_model_inst.drive(2, 1'h0);
    repeat (10) @(posedge hclk);
    rdc(IDX_CAPTURE, 32'h0BCD);
    ext_pins_model_inst.drive(2, 1'h1);
    repeat (12) @(posedge hclk);
    rdc(IDX_CAPTURE, 32'h0111);
    wr(IDX_C1_CTRL_B, 32'h140);
    wr(IDX_C1_VALUE, 32'h0222);
    ext_pins_model_inst.drive(3, 1'h1);
    repeat (10) @(posedge hclk);
    rdc(IDX_CAPTURE, 32'h0222);
    $display("test capture done");
    finish_test();
  end
endmodule
